/* pwm_timer_map.vh */
`ifndef PWM_TIMER_MAP_VH
`define PWM_TIMER_MAP_VH

// ==========================================================
// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_IRQ_EN      8'h04
`define OFS_OUT_POL     8'h08
`define OFS_PRESCALE    8'h0C
`define OFS_RELOAD      8'h10
`define OFS_CMP1        8'h14
`define OFS_CMP2        8'h18
`define OFS_CMP3        8'h1C
`define OFS_CMP4        8'h20
`define OFS_OC_MODE     8'h24
`define OFS_DEADTIME    8'h28
`define OFS_IDLE_LVL    8'h2C
`define OFS_INIT_CNT    8'h30
`define OFS_STATUS      8'h34

// ==========================================================
// timer_control_reg fields
`define CTRL_RUN        0
`define CTRL_UPDATE_DISABLE       1
`define CTRL_DIR        2
`define CTRL_CMS_LO     3
`define CTRL_CMS_HI     4
`define CTRL_INIT_DIR   5
`define CTRL_RELOAD_PRELOAD_ENABLE       7
`define CTRL_CKD_LO     8
`define CTRL_CKD_HI     9
`define CTRL_W          10
`define CTRL_RESET      10'h000

// ==========================================================
// alignment, modes and divisions
`define CMS_EDGE        2'h0
`define CMS_DOWN_ONLY   2'h1
`define CMS_UP_ONLY     2'h2
`define CMS_BOTH        2'h3
`define OCM_FROZEN      3'h0
`define OCM_SET         3'h1
`define OCM_CLEAR       3'h2
`define OCM_TOGGLE      3'h3
`define OCM_FORCE_LO    3'h4
`define OCM_FORCE_HI    3'h5
`define OCM_PWM1        3'h6
`define OCM_PWM2        3'h7
`define CKD_DIV1        2'h0
`define CKD_DIV2        2'h1
`define CKD_SHIFT1      2'h0
`define CKD_SHIFT2      2'h1
`define CKD_SHIFT4      2'h2

// ==========================================================
// other field layouts and constants
`define IE_UPDATE       0
`define IE_W            5
`define OUT_POL_W       16
`define MOE_BIT         15
`define IDLE_W          7
`define DT_W            12
`define DT_BASE64       12'h040
`define DT_BASE32       12'h020
`define CNT_W           16
`define CNT_ONE         16'h0001
`define CNT_ZERO        16'h0000
`define WORD_ZERO       32'h00000000
`define REG16_RESET     16'h0000
`define RELOAD_RESET    16'hFFFF

`endif

/* dead_time_channel.v */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_map.vh"

module dead_time_channel
(
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             ref_in,
	input  wire             dts_tick,
	input  wire [`DT_W-1:0] dt_len,
	output wire             main_raw,
	output wire             compl_raw
);

	reg             ref_d_r;
	reg [`DT_W-1:0] wait_r;

	// ==========================================================
	// delay of each rising edge
	// rising edge delay
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ref_d_r <= 1'b0;
			wait_r  <= {`DT_W{1'b0}};
		end
		else if (ref_in != ref_d_r)
		begin
			ref_d_r <= ref_in;
			wait_r  <= dt_len;
		end
		else if (dts_tick && (wait_r != {`DT_W{1'b0}}))
		begin
			wait_r <= wait_r - {{(`DT_W-1){1'b0}}, 1'b1};
		end
	end

	// both sides low while waiting, so the switches never overlap
	assign main_raw  = ref_d_r & (wait_r == {`DT_W{1'b0}});
	assign compl_raw = ~ref_d_r & (wait_r == {`DT_W{1'b0}});

endmodule // dead_time_channel

`default_nettype wire

/* multi_channel_pwm_timer.v */
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_map.vh"

module multi_channel_pwm_timer
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        resync_in,
	output reg         update_flag,
	output reg  [3:0]  compare_match_flag,
	output reg  [3:0]  main_output,
	output reg  [2:0]  complementary_output
);

	// ==========================================================
	// registers
	reg [`CTRL_W-1:0]    ctrl_r;
	reg [`IE_W-1:0]      ie_r;
	reg [`OUT_POL_W-1:0] oep_r;
	reg [`CNT_W-1:0]     psc_r;
	reg [`CNT_W-1:0]     arr_r;
	reg [`CNT_W-1:0]     ccr_r [0:3];
	reg [15:0]           mode_r;
	reg [15:0]           bdt_r;
	reg [`IDLE_W-1:0]    idle_r;
	reg [`CNT_W-1:0]     init_r;
	reg [`CNT_W-1:0]     arr_sh_r;
	reg [`CNT_W-1:0]     ccr_sh_r [0:3];
	reg [15:0]           mode_sh_r;
	reg [`CNT_W-1:0]     cnt_r;
	reg                  down_r;
	reg [`CNT_W-1:0]     psc_cnt_r;
	reg [`DT_W-1:0]      dt_code;
	reg                  run_d_r;
	reg                  sync_d_r;
	reg [3:0]            ref_r;
	reg                  wr_pend_r;
	reg [7:0]            wr_addr_r;
	reg [31:0]           rd_nxt;
	reg [`CNT_W-1:0]     cnt_nxt;
	reg                  down_nxt;
	reg                  wrap_ev;
	reg [`DT_W-1:0]      dt_len;
	reg [1:0]            dts_shift;
	reg [3:0]            ref_nxt;
	reg [3:0]            main_nxt;
	reg [2:0]            compl_nxt;
	integer              i;
	integer              j;

	wire                 bus_sel;
	wire [7:0]           aofs;
	wire [1:0]           alignment_select;
	wire                 center;
	wire                 tick;
	wire                 dts_tick;
	wire                 start;
	wire                 sync_rise;
	wire                 upd_ev;
	wire                 load_cfg;
	wire [`CNT_W-1:0]    arr_act;
	wire                 flag_dir_ok;
	wire [3:0]           match;
	wire [2:0]           dt_main;
	wire [2:0]           dt_compl;

	// ==========================================================
	// ahb-lite slave, zero wait states
	assign bus_sel = hsel & htrans[1] & hready;
	assign aofs    = haddr[7:0];

	always @*
	begin
		rd_nxt = `WORD_ZERO;
		if (aofs == `OFS_CTRL)
			rd_nxt[`CTRL_W-1:0] = ctrl_r;
		else if (aofs == `OFS_IRQ_EN)
			rd_nxt[`IE_W-1:0] = ie_r;
		else if (aofs == `OFS_OUT_POL)
			rd_nxt[`OUT_POL_W-1:0] = oep_r;
		else if (aofs == `OFS_PRESCALE)
			rd_nxt[`CNT_W-1:0] = psc_r;
		else if (aofs == `OFS_RELOAD)
			rd_nxt[`CNT_W-1:0] = arr_r;
		else if (aofs == `OFS_CMP1)
			rd_nxt[`CNT_W-1:0] = ccr_r[0];
		else if (aofs == `OFS_CMP2)
			rd_nxt[`CNT_W-1:0] = ccr_r[1];
		else if (aofs == `OFS_CMP3)
			rd_nxt[`CNT_W-1:0] = ccr_r[2];
		else if (aofs == `OFS_CMP4)
			rd_nxt[`CNT_W-1:0] = ccr_r[3];
		else if (aofs == `OFS_OC_MODE)
			rd_nxt[15:0] = mode_r;
		else if (aofs == `OFS_DEADTIME)
			rd_nxt[15:0] = bdt_r;
		else if (aofs == `OFS_IDLE_LVL)
			rd_nxt[`IDLE_W-1:0] = idle_r;
		else if (aofs == `OFS_INIT_CNT)
			rd_nxt[`CNT_W-1:0] = init_r;
		else if (aofs == `OFS_STATUS)
			rd_nxt[`CNT_W:0] = {down_r, cnt_r};
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata    <= `WORD_ZERO;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end
		else
		begin
			wr_pend_r <= bus_sel & hwrite;
			if (bus_sel)
				wr_addr_r <= aofs;
			if (bus_sel && !hwrite)
				hrdata <= rd_nxt;
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_r   <= `CTRL_RESET;
			ie_r     <= {`IE_W{1'b0}};
			oep_r    <= `REG16_RESET;
			psc_r    <= `REG16_RESET;
			arr_r    <= `RELOAD_RESET;
			ccr_r[0] <= `REG16_RESET;
			ccr_r[1] <= `REG16_RESET;
			ccr_r[2] <= `REG16_RESET;
			ccr_r[3] <= `REG16_RESET;
			mode_r   <= `REG16_RESET;
			bdt_r    <= `REG16_RESET;
			idle_r   <= {`IDLE_W{1'b0}};
			init_r   <= `REG16_RESET;
		end
		else if (wr_pend_r)
		begin
			if (wr_addr_r == `OFS_CTRL)
				ctrl_r <= hwdata[`CTRL_W-1:0];
			else if (wr_addr_r == `OFS_IRQ_EN)
				ie_r <= hwdata[`IE_W-1:0];
			else if (wr_addr_r == `OFS_OUT_POL)
				oep_r <= hwdata[`OUT_POL_W-1:0];
			else if (wr_addr_r == `OFS_PRESCALE)
				psc_r <= hwdata[`CNT_W-1:0];
			else if (wr_addr_r == `OFS_RELOAD)
				arr_r <= hwdata[`CNT_W-1:0];
			else if (wr_addr_r == `OFS_CMP1)
				ccr_r[0] <= hwdata[`CNT_W-1:0];
			else if (wr_addr_r == `OFS_CMP2)
				ccr_r[1] <= hwdata[`CNT_W-1:0];
			else if (wr_addr_r == `OFS_CMP3)
				ccr_r[2] <= hwdata[`CNT_W-1:0];
			else if (wr_addr_r == `OFS_CMP4)
				ccr_r[3] <= hwdata[`CNT_W-1:0];
			else if (wr_addr_r == `OFS_OC_MODE)
				mode_r <= hwdata[15:0];
			else if (wr_addr_r == `OFS_DEADTIME)
				bdt_r <= hwdata[15:0];
			else if (wr_addr_r == `OFS_IDLE_LVL)
				idle_r <= hwdata[`IDLE_W-1:0];
			else if (wr_addr_r == `OFS_INIT_CNT)
				init_r <= hwdata[`CNT_W-1:0];
		end
	end

	// ==========================================================
	// prescaler and dead-time tick
	assign alignment_select    = ctrl_r[`CTRL_CMS_HI:`CTRL_CMS_LO];
	assign center = (alignment_select != `CMS_EDGE);
	assign tick   = ctrl_r[`CTRL_RUN] & (psc_cnt_r == psc_r);

	// dead time tick division
	// waits scaled in counter ticks: a free divider would lose up to one phase
	always @*
	begin
		if (ctrl_r[`CTRL_CKD_HI:`CTRL_CKD_LO] == `CKD_DIV1)
			dts_shift = `CKD_SHIFT1;
		else if (ctrl_r[`CTRL_CKD_HI:`CTRL_CKD_LO] == `CKD_DIV2)
			dts_shift = `CKD_SHIFT2;
		else
			dts_shift = `CKD_SHIFT4;
	end
	assign dts_tick = tick;

	always @*
	begin
		if (!bdt_r[7])
			dt_code = {5'h00, bdt_r[6:0]};
		else if (!bdt_r[6])
			dt_code = (`DT_BASE64 + {6'h00, bdt_r[5:0]}) << 1;
		else if (!bdt_r[5])
			dt_code = (`DT_BASE32 + {7'h00, bdt_r[4:0]}) << 3;
		else
			dt_code = (`DT_BASE32 + {7'h00, bdt_r[4:0]}) << 4;
		dt_len = dt_code << dts_shift;
	end

	// ==========================================================
	// counter
	// preload when CTRL bit 7 is set, direct path kept otherwise
	assign arr_act = ctrl_r[`CTRL_RELOAD_PRELOAD_ENABLE] ? arr_sh_r : arr_r;

	always @*
	begin
		cnt_nxt  = cnt_r;
		down_nxt = down_r;
		wrap_ev  = 1'b0;
		if (!center)
		begin
			down_nxt = ctrl_r[`CTRL_DIR];
			if (!ctrl_r[`CTRL_DIR])
			begin
				wrap_ev = (cnt_r >= arr_act);
				cnt_nxt = wrap_ev ? `CNT_ZERO : cnt_r + `CNT_ONE;
			end
			else
			begin
				wrap_ev = (cnt_r == `CNT_ZERO);
				cnt_nxt = wrap_ev ? arr_act : cnt_r - `CNT_ONE;
			end
		end
		else if (!down_r)
		begin
			wrap_ev = (cnt_r >= arr_act);
			if (wrap_ev)
			begin
				down_nxt = 1'b1;
				cnt_nxt  = arr_act - `CNT_ONE;
			end
			else
				cnt_nxt = cnt_r + `CNT_ONE;
		end
		else
		begin
			wrap_ev = (cnt_r == `CNT_ZERO);
			if (wrap_ev)
			begin
				down_nxt = 1'b0;
				cnt_nxt  = `CNT_ONE;
			end
			else
				cnt_nxt = cnt_r - `CNT_ONE;
		end
	end

	assign start     = ctrl_r[`CTRL_RUN] & ~run_d_r;
	assign sync_rise = resync_in & ~sync_d_r;
	assign upd_ev    = tick & wrap_ev & ~ctrl_r[`CTRL_UPDATE_DISABLE];
	assign load_cfg  = upd_ev | sync_rise | start;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_r     <= `CNT_ZERO;
			down_r    <= 1'b0;
			psc_cnt_r <= `CNT_ZERO;
			run_d_r   <= 1'b0;
			sync_d_r  <= 1'b0;
		end
		else
		begin
			run_d_r  <= ctrl_r[`CTRL_RUN];
			sync_d_r <= resync_in;
			if (start)
			begin
				cnt_r     <= init_r;
				down_r    <= center ? ctrl_r[`CTRL_INIT_DIR] : ctrl_r[`CTRL_DIR];
				psc_cnt_r <= `CNT_ZERO;
			end
			else if (sync_rise)
			begin
				cnt_r     <= `CNT_ZERO;
				psc_cnt_r <= `CNT_ZERO;
			end
			else if (ctrl_r[`CTRL_RUN])
			begin
				psc_cnt_r <= tick ? `CNT_ZERO : psc_cnt_r + `CNT_ONE;
				if (tick)
				begin
					cnt_r     <= cnt_nxt;
					down_r    <= down_nxt;
				end
			end
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			arr_sh_r    <= `RELOAD_RESET;
			mode_sh_r   <= `REG16_RESET;
			ccr_sh_r[0] <= `REG16_RESET;
			ccr_sh_r[1] <= `REG16_RESET;
			ccr_sh_r[2] <= `REG16_RESET;
			ccr_sh_r[3] <= `REG16_RESET;
		end
		else if (load_cfg)
		begin
			arr_sh_r  <= arr_r;
			mode_sh_r   <= mode_r;
			ccr_sh_r[0] <= ccr_r[0];
			ccr_sh_r[1] <= ccr_r[1];
			ccr_sh_r[2] <= ccr_r[2];
			ccr_sh_r[3] <= ccr_r[3];
		end
	end

	// ==========================================================
	// compare, references and flags
	// flag direction by alignment
	assign flag_dir_ok = (alignment_select == `CMS_EDGE) | (alignment_select == `CMS_BOTH) |
	                     ((alignment_select == `CMS_DOWN_ONLY) & down_r) |
	                     ((alignment_select == `CMS_UP_ONLY) & ~down_r);

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : cmp
			assign match[g] = tick & flag_dir_ok & (cnt_r == ccr_sh_r[g]);
		end
	endgenerate

	always @*
	begin
		ref_nxt = ref_r;
		for (j = 0; j < 4; j = j + 1)
		begin
			case (mode_sh_r[4*j +: 3])
				`OCM_SET:      ref_nxt[j] = match[j] ? 1'b1 : ref_r[j];
				`OCM_CLEAR:    ref_nxt[j] = match[j] ? 1'b0 : ref_r[j];
				`OCM_TOGGLE:   ref_nxt[j] = match[j] ? ~ref_r[j] : ref_r[j];
				`OCM_FORCE_LO: ref_nxt[j] = 1'b0;
				`OCM_FORCE_HI: ref_nxt[j] = 1'b1;
				`OCM_PWM1:     ref_nxt[j] = (cnt_r < ccr_sh_r[j]);
				`OCM_PWM2:     ref_nxt[j] = ~(cnt_r < ccr_sh_r[j]);
				default:       ref_nxt[j] = ref_r[j];
			endcase
		end
	end

	generate
		for (g = 0; g < 3; g = g + 1)
		begin : dt
			// dead time on channels one to three
			dead_time_channel u_dt
			(
				.hclk      (hclk),
				.hresetn   (hresetn),
				.ref_in    (ref_r[g]),
				.dts_tick  (dts_tick),
				.dt_len    (dt_len),
				.main_raw  (dt_main[g]),
				.compl_raw (dt_compl[g])
			);
		end
	endgenerate

	// ==========================================================
	// output stage, never preloaded
	// live polarity and enables
	always @*
	begin
		main_nxt  = 4'h0;
		compl_nxt = 3'h0;
		for (i = 0; i < 3; i = i + 1)
		begin
			case ({oep_r[4*i+2], oep_r[4*i]})
				2'b00:
				begin
					main_nxt[i]  = 1'b0;
					compl_nxt[i] = 1'b0;
				end
				2'b01:
				begin
					main_nxt[i]  = ref_r[i];
					compl_nxt[i] = 1'b0;
				end
				2'b10:
				begin
					main_nxt[i]  = 1'b0;
					compl_nxt[i] = ref_r[i];
				end
				default:
				begin
					main_nxt[i]  = dt_main[i];
					compl_nxt[i] = dt_compl[i];
				end
			endcase
			main_nxt[i]  = main_nxt[i] ^ oep_r[4*i+1];
			compl_nxt[i] = compl_nxt[i] ^ oep_r[4*i+3];
		end
		main_nxt[3] = oep_r[12] ? idle_r[3] : (ref_r[3] ^ oep_r[13]);
		if (!bdt_r[`MOE_BIT])
		begin
			main_nxt  = idle_r[3:0];
			compl_nxt = idle_r[6:4];
		end
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ref_r                <= 4'h0;
			update_flag          <= 1'b0;
			compare_match_flag   <= 4'h0;
			main_output          <= 4'h0;
			complementary_output <= 3'h0;
		end
		else
		begin
			ref_r <= ref_nxt;
			update_flag          <= upd_ev & ie_r[`IE_UPDATE];
			compare_match_flag   <= match & ie_r[4:1];
			main_output          <= main_nxt;
			complementary_output <= compl_nxt;
		end
	end

endmodule // multi_channel_pwm_timer

`default_nettype wire

/* gate_driver_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========
// gate driver and trigger sink
// counts events; dead gap runs from main fall to compl rise
module gate_driver_model
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        update_flag,
	input  wire logic        cmp_flag,
	input  wire logic        main_in,
	input  wire logic        compl_in,
	output logic [15:0] upd_cnt,
	output logic [15:0] cmp_cnt,
	output logic [15:0] hi_cnt,
	output logic [15:0] dt_gap
);
	logic        main_q;
	logic        compl_q;
	logic [15:0] run_cnt;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			upd_cnt <= 16'h0000;
			cmp_cnt <= 16'h0000;
			hi_cnt  <= 16'h0000;
			dt_gap  <= 16'h0000;
			run_cnt <= 16'h0000;
			main_q  <= 1'b0;
			compl_q <= 1'b0;
		end
		else
		begin
			upd_cnt <= upd_cnt + {15'h0000, update_flag};
			cmp_cnt <= cmp_cnt + {15'h0000, cmp_flag};
			hi_cnt  <= hi_cnt + {15'h0000, main_in};
			main_q  <= main_in;
			compl_q <= compl_in;
			run_cnt <= (main_q && !main_in) ? 16'h0001 : run_cnt + 16'h0001;
			if (!compl_q && compl_in)
				dt_gap <= run_cnt;
		end
	end
endmodule // gate_driver_model

`default_nettype wire

/* pwm_timer_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_map.vh"

module pwm_timer_props
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        update_flag,
	input wire logic [3:0]  compare_match_flag,
	input wire logic [3:0]  main_output,
	input wire logic [2:0]  complementary_output
);
	// ==========
	// write tracking
	// quiet_r guards against flags launched just before a write lands
	reg       wr_r;
	reg [7:0] wa_r;
	reg [4:0] ie_r;
	reg [6:0] idle_r;
	reg       gate_r;
	reg       run_r;
	reg [1:0] quiet_r;
	wire      rd_go = hsel && htrans[1] && hready && !hwrite;
	wire      land  = wr_r && hready;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_r    <= 1'b0;
			wa_r    <= 8'h00;
			ie_r    <= 5'h00;
			idle_r  <= 7'h00;
			gate_r  <= 1'b0;
			run_r   <= 1'b0;
			quiet_r <= 2'h0;
		end
		else
		begin
			wr_r    <= hsel && htrans[1] && hready && hwrite;
			wa_r    <= haddr[7:0];
			quiet_r <= land ? 2'h0 : (quiet_r == 2'h3) ? 2'h3 : quiet_r + 2'h1;
			if (land && wa_r == `OFS_IRQ_EN)
				ie_r <= hwdata[4:0];
			if (land && wa_r == `OFS_IDLE_LVL)
				idle_r <= hwdata[6:0];
			if (land && wa_r == `OFS_DEADTIME)
				gate_r <= hwdata[15];
			if (land && wa_r == `OFS_CTRL)
				run_r <= hwdata[0];
		end
	end

	// ==========
	// properties
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus answer not zero wait okay");
	a_update_pulse: assert property (update_flag |=> !update_flag)
		else $error("update flag held");
	a_cmp_pulse: assert property (|compare_match_flag |=>
		(compare_match_flag & $past(compare_match_flag)) == 4'h0) else $error("compare flag held");
	a_upd_gated: assert property (quiet_r == 2'h3 && update_flag |-> ie_r[0])
		else $error("update flag while disabled");
	a_cmp_gated: assert property (quiet_r == 2'h3 |->
		(compare_match_flag & ~ie_r[4:1]) == 4'h0) else $error("compare flag while disabled");
	a_idle_level: assert property (quiet_r == 2'h3 && !gate_r |->
		main_output == idle_r[3:0] && complementary_output == idle_r[6:4])
		else $error("ungated outputs not at idle level");
	a_stop_quiet: assert property (quiet_r == 2'h3 && !run_r |->
		!update_flag && compare_match_flag == 4'h0) else $error("flags while stopped");
	a_read_irq: assert property (rd_go && haddr[7:0] == `OFS_IRQ_EN |=>
		hrdata == {27'h0000000, $past(ie_r)}) else $error("enable readback wrong");
	a_unmapped_zero: assert property (rd_go && haddr[7:0] == 8'h38 |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule // pwm_timer_props

bind multi_channel_pwm_timer pwm_timer_props chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.update_flag(update_flag), .compare_match_flag(compare_match_flag),
	.main_output(main_output), .complementary_output(complementary_output));

`default_nettype wire

/* multi_channel_pwm_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_map.vh"

module multi_channel_pwm_timer_bench;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = `WORD_ZERO;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = `WORD_ZERO;
	logic        resync_in = 1'b0;
	wire         hready;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         update_flag;
	wire  [3:0]  compare_match_flag;
	wire  [3:0]  main_output;
	wire  [2:0]  complementary_output;
	wire  [15:0] upd_cnt, cmp_cnt, hi_cnt, dt_gap;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [31:0] rd;
	logic [15:0] du, dc, dh;
	logic [31:0] om = 32'h76405321;
	logic [63:0] ex = 64'h0604000A0A05000A;
	logic [47:0] gt = 48'h0303E0C18103;
	logic [11:0] gk = 12'h900;

	assign hready = hreadyout;
	always #2 hclk = ~hclk;

	multi_channel_pwm_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .resync_in(resync_in),
		.update_flag(update_flag), .compare_match_flag(compare_match_flag),
		.main_output(main_output), .complementary_output(complementary_output));
	gate_driver_model drv (.hclk(hclk), .hresetn(hresetn), .update_flag(update_flag),
		.cmp_flag(compare_match_flag[0]), .main_in(main_output[0]),
		.compl_in(complementary_output[0]), .upd_cnt(upd_cnt), .cmp_cnt(cmp_cnt),
		.hi_cnt(hi_cnt), .dt_gap(dt_gap));

	// ==========
	// bus and check tasks
	task tally_and_finish;
	begin
		$display("checks %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
	begin
		xfer(1'b0, a, `WORD_ZERO);
		chk(rd, exp);
	end
	endtask

	// restart so that shadows and the counter load from the written setup
	task automatic go(input logic [31:0] c);
	begin
		wr(`OFS_CTRL, `WORD_ZERO);
		wr(`OFS_CTRL, c);
		repeat (40) @(posedge hclk);
	end
	endtask

	// windows span whole periods, so the counts do not depend on phase
	task automatic meas(input int n);
	begin
		@(negedge hclk);
		du = upd_cnt;
		dc = cmp_cnt;
		dh = hi_cnt;
		repeat (n) @(negedge hclk);
		du = upd_cnt - du;
		dc = cmp_cnt - dc;
		dh = hi_cnt - dh;
		@(posedge hclk);
	end
	endtask

	function automatic int dt_exp(input logic [7:0] g, input logic [1:0] k);
		int b;
		b = !g[7] ? g : !g[6] ? (64 + g[5:0]) * 2 : (32 + g[4:0]) * (g[5] ? 16 : 8);
		return b << k;
	endfunction

	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			error_cnt = error_cnt + 1;
			tally_and_finish;
		end
	end

	// ==========
	// sequence
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk(`OFS_IRQ_EN, `WORD_ZERO);
		rchk(`OFS_OUT_POL, `WORD_ZERO);
		rchk(`OFS_RELOAD, 32'h0000FFFF);
		rchk(8'h38, `WORD_ZERO);
		wr(`OFS_IRQ_EN, 32'hFFFFFFFF);
		rchk(`OFS_IRQ_EN, 32'h0000001F);
		wr(`OFS_OUT_POL, 32'hFFFFFFFF);
		rchk(`OFS_OUT_POL, 32'h0000FFFF);
		wr(`OFS_OUT_POL, 32'h00000001);
		wr(`OFS_DEADTIME, 32'h00008000);
		wr(`OFS_PRESCALE, 32'h00000001);
		wr(`OFS_RELOAD, 32'h00000005);
		wr(`OFS_CMP1, 32'h00000002);
		go(32'h00000081);
		meas(36);
		chk({16'h0000, du}, 3);
		chk({16'h0000, dc}, 3);
		wr(`OFS_IRQ_EN, 32'h0000001E);
		meas(36);
		chk({16'h0000, du}, 0);
		chk({16'h0000, dc}, 3);
		wr(`OFS_IRQ_EN, 32'h0000001F);
		go(32'h00000085);
		meas(36);
		chk({16'h0000, du}, 3);
		xfer(1'b0, `OFS_STATUS, `WORD_ZERO);
		chk({31'h00000000, rd[16]}, 1);
		for (int m = 1; m < 4; m++)
		begin
			go(32'h00000081 | (m << 3));
			meas(60);
			chk({16'h0000, du}, 6);
			chk({16'h0000, dc}, (m == 3) ? 6 : 3);
		end
		wr(`OFS_PRESCALE, `WORD_ZERO);
		wr(`OFS_RELOAD, 32'h00000004);
		go(32'h00000081);
		for (int i = 0; i < 8; i++)
		begin
			wr(`OFS_OC_MODE, {29'h00000000, om[4*i+:3]});
			repeat (15) @(posedge hclk);
			meas(10);
			chk({16'h0000, dh}, {24'h000000, ex[8*i+:8]});
		end
		wr(`OFS_OUT_POL, 32'h00000003);
		repeat (3) @(posedge hclk);
		meas(10);
		chk({16'h0000, dh}, 4);
		wr(`OFS_OUT_POL, 32'h00000005);
		wr(`OFS_OC_MODE, 32'h00000006);
		wr(`OFS_RELOAD, 32'h000004B0);
		wr(`OFS_CMP1, 32'h00000258);
		for (int i = 0; i < 6; i++)
		begin
			wr(`OFS_DEADTIME, {24'h000080, gt[8*i+:8]});
			go(32'h00000081 | {22'h000000, gk[2*i+:2], 8'h00});
			repeat (3700) @(posedge hclk);
			chk({16'h0000, dt_gap}, dt_exp(gt[8*i+:8], gk[2*i+:2]));
		end
		wr(`OFS_PRESCALE, 32'h00000063);
		wr(`OFS_INIT_CNT, 32'h00000007);
		go(32'h00000081);
		rchk(`OFS_STATUS, 32'h00000007);
		resync_in <= 1'b1;
		@(posedge hclk);
		resync_in <= 1'b0;
		@(posedge hclk);
		rchk(`OFS_STATUS, `WORD_ZERO);
		wr(`OFS_IDLE_LVL, 32'h0000007F);
		repeat (3) @(posedge hclk);
		chk({31'h00000000, main_output[3]}, 0);
		wr(`OFS_OUT_POL, 32'h00001005);
		repeat (3) @(posedge hclk);
		chk({31'h00000000, main_output[3]}, 1);
		wr(`OFS_DEADTIME, `WORD_ZERO);
		repeat (5) @(posedge hclk);
		chk({25'h0000000, complementary_output, main_output}, 32'h0000007F);
		wr(`OFS_CTRL, `WORD_ZERO);
		repeat (10) @(posedge hclk);
		tally_and_finish;
	end
endmodule // multi_channel_pwm_timer_bench

`default_nettype wire
